// ---- design/xr_ext_mode.sv ----
`timescale 1ns/1ps
`include "xr_ext_mode_regs.svh"

module xr_ext_mode
(
  // Clock and reset
  input  wire logic        ref_clk_i,
  input  wire logic        arst_n_i,
  // APB slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // Transmit engine events
  input  wire logic        tx_start_i,
  input  wire logic        backoff_start_i,
  input  wire logic        frame_tx_start_i,
  input  wire logic        cca_busy_i,
  input  wire logic        no_ack_i,
  input  wire logic        wake_i,
  output logic             csma_bypass_o,
  output logic             retry_backoff_o,
  output logic             retry_frame_o,
  output logic             cancel_o,
  output logic      [10:0] backoff_random_o,
  output logic      [2:0]  transaction_status_o,
  // Receive side
  input  wire logic        auto_acknowledge_mode_i,
  input  wire logic        rx_done_i,
  input  wire logic        rx_ack_req_i,
  input  wire logic        rx_data_req_i,
  input  wire logic [1:0]  rx_frame_version_i,
  input  wire logic        sleep_trigger_pin_i,
  output logic             rx_accept_o,
  output logic             ack_send_o,
  output logic             ack_pending_o,
  output logic      [1:0]  ack_frame_version_o,
  output logic             pan_coordinator_flag_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release
  logic rst_s1_r;
  logic rst_n_r;

  always_ff @(posedge ref_clk_i or negedge arst_n_i)
  begin
    if (!arst_n_i)
    begin
      rst_s1_r <= 1'b0;
      rst_n_r  <= 1'b0;
    end
    else
    begin
      rst_s1_r <= 1'b1;
      rst_n_r  <= rst_s1_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers and decode
  logic [7:0] tx_control_r;
  logic [7:0] seed_low_r;
  logic [7:0] ack_ctrl_r;
  logic [3:0] frame_cnt_r;
  logic [2:0] csma_cnt_r;
  logic [3:0] frame_shown_r;
  logic [2:0] csma_shown_r;

  wire        word_ok   = (paddr_i[1:0] == 2'b00);
  wire        hit_stat  = word_ok && paddr_i[7:2] == `XR_IDX_RETRY_STATUS;
  wire        hit_txc   = word_ok && paddr_i[7:2] == `XR_IDX_TX_CONTROL;
  wire        hit_seed  = word_ok && paddr_i[7:2] == `XR_IDX_SEED_LOW;
  wire        hit_ack   = word_ok && paddr_i[7:2] == `XR_IDX_ACK_CTRL_SEED;
  wire        hit_any   = hit_stat | hit_txc | hit_seed | hit_ack;
  wire        setup     = psel_i & ~penable_i;
  wire        wr_commit = psel_i & penable_i & pready_o & pwrite_i & hit_any;
  wire [7:0]  status_rd = {frame_shown_r, csma_shown_r, 1'b0};
  wire [7:0]  rd_byte   = hit_stat ? status_rd :
                          hit_txc  ? tx_control_r :
                          hit_seed ? seed_low_r :
                          hit_ack  ? ack_ctrl_r : 8'h00;

  // Data and answer prepared in setup so access phase ends at once
  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= setup;
      pslverr_o <= setup & ~hit_any;
      prdata_o  <= {24'h00_0000, rd_byte};
    end
  end

  // Status register is read only; writes to it are dropped
  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      tx_control_r <= `XR_RST_TX_CONTROL;
      seed_low_r   <= `XR_RST_SEED_LOW;
      ack_ctrl_r   <= `XR_RST_ACK_CTRL_SEED;
    end
    else if (wr_commit)
    begin
      if (hit_txc)
        tx_control_r <= pwdata_i[7:0];
      if (hit_seed)
        seed_low_r <= pwdata_i[7:0];
      if (hit_ack)
        ack_ctrl_r <= pwdata_i[7:0];
    end
  end

  wire [3:0] frame_limit = tx_control_r[`XR_FRAME_LIM_MSB:`XR_FRAME_LIM_LSB];
  wire [2:0] csma_limit  = tx_control_r[`XR_CSMA_LIM_MSB:`XR_CSMA_LIM_LSB];
  wire       slotted     = tx_control_r[`XR_SLOTTED_BIT];
  wire [1:0] fvn_mode    = ack_ctrl_r[`XR_FVN_MSB:`XR_FVN_LSB];
  wire       set_pending = ack_ctrl_r[`XR_SET_PD_BIT];
  wire       ack_disable = ack_ctrl_r[`XR_DIS_ACK_BIT];
  wire [10:0] seed       = {ack_ctrl_r[`XR_SEED_HI_MSB:0], seed_low_r};
  wire       immediate   = (csma_limit == `XR_CSMA_IMMEDIATE);

  ////////////////////////////////////////////////////////////////////////////
  // Retry counting and limits
  wire csma_more  = ~immediate && (csma_cnt_r < csma_limit);
  wire frame_more = ~immediate && (frame_cnt_r < frame_limit);

  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      frame_cnt_r     <= 4'h0;
      csma_cnt_r      <= 3'h0;
      retry_backoff_o <= 1'b0;
      retry_frame_o   <= 1'b0;
      cancel_o        <= 1'b0;
      csma_bypass_o   <= 1'b0;
    end
    else
    begin
      retry_backoff_o <= 1'b0;
      retry_frame_o   <= 1'b0;
      cancel_o        <= 1'b0;
      csma_bypass_o   <= immediate;
      if (tx_start_i)
      begin
        frame_cnt_r <= 4'h0;
        csma_cnt_r  <= 3'h0;
      end
      else if (cca_busy_i && !immediate)
      begin
        if (csma_more)
        begin
          csma_cnt_r      <= csma_cnt_r + 3'h1;
          retry_backoff_o <= 1'b1;
        end
        else
          cancel_o <= 1'b1;
      end
      else if (no_ack_i)
      begin
        if (frame_more)
        begin
          frame_cnt_r   <= frame_cnt_r + 4'h1;
          csma_cnt_r    <= 3'h0;
          retry_frame_o <= 1'b1;
        end
        else
          cancel_o <= 1'b1;
      end
    end
  end

  // Visible counters follow the live ones at each new cycle
  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      frame_shown_r <= 4'h0;
      csma_shown_r  <= 3'h0;
    end
    else if (tx_start_i)
    begin
      frame_shown_r <= 4'h0;
      csma_shown_r  <= 3'h0;
    end
    else if (backoff_start_i || frame_tx_start_i)
    begin
      frame_shown_r <= frame_cnt_r;
      csma_shown_r  <= csma_cnt_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Backoff random generator, x^11 + x^9 + 1
  wire [10:0] seed_safe = (seed == 11'h000) ? 11'h001 : seed;
  wire        lfsr_fb   = backoff_random_o[10] ^ backoff_random_o[8];

  // Reloaded at reset release too, so the reset seed is honoured
  logic seed_loaded_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      seed_loaded_r    <= 1'b0;
      backoff_random_o <= 11'h001;
    end
    else
    begin
      seed_loaded_r <= 1'b1;
      if (wake_i || !seed_loaded_r)
        backoff_random_o <= seed_safe;
      else
        backoff_random_o <= {backoff_random_o[9:0], lfsr_fb};
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Trigger pin synchroniser; a change counts when stages 2 and 3 agree
  logic trig_s1_r;
  logic trig_s2_r;
  logic trig_s3_r;
  logic trig_lvl_r;

  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      trig_s1_r  <= 1'b0;
      trig_s2_r  <= 1'b0;
      trig_s3_r  <= 1'b0;
      trig_lvl_r <= 1'b0;
    end
    else
    begin
      trig_s1_r <= sleep_trigger_pin_i;
      trig_s2_r <= trig_s1_r;
      trig_s3_r <= trig_s2_r;
      if (trig_s2_r == trig_s3_r)
        trig_lvl_r <= trig_s3_r;
    end
  end

  wire trig_rise = trig_s2_r & trig_s3_r & ~trig_lvl_r;

  ////////////////////////////////////////////////////////////////////////////
  // Receive filtering and acknowledgement
  xr_pkg::xr_ack_state_t ack_state_r;
  xr_pkg::xr_ack_state_t ack_state_nxt;
  xr_pkg::xr_trac_t      trac_r;
  logic                  hold_pending_r;

  // Mode 3 covers every version through the plain compare
  wire version_ok = (rx_frame_version_i <= fvn_mode);
  wire accept     = rx_done_i & auto_acknowledge_mode_i & version_ok;
  wire want_ack   = accept & rx_ack_req_i & ~ack_disable;
  wire pend_now   = rx_data_req_i & set_pending;
  wire fire_now   = want_ack & ~slotted;
  wire fire_held  = (ack_state_r == xr_pkg::XR_ACK_HOLD) & trig_rise;

  always_comb
  begin
    ack_state_nxt = ack_state_r;
    case (ack_state_r)
      xr_pkg::XR_ACK_IDLE:
        if (want_ack && slotted)
          ack_state_nxt = xr_pkg::XR_ACK_HOLD;
      xr_pkg::XR_ACK_HOLD:
        if (trig_rise)
          ack_state_nxt = xr_pkg::XR_ACK_IDLE;
      default:
        ack_state_nxt = xr_pkg::XR_ACK_IDLE;
    endcase
  end

  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
    begin
      ack_state_r         <= xr_pkg::XR_ACK_IDLE;
      hold_pending_r      <= 1'b0;
      rx_accept_o         <= 1'b0;
      ack_send_o          <= 1'b0;
      ack_pending_o       <= 1'b0;
      ack_frame_version_o <= 2'h0;
      pan_coordinator_flag_o <= 1'b0;
    end
    else
    begin
      ack_state_r         <= ack_state_nxt;
      rx_accept_o         <= accept;
      ack_send_o          <= fire_now | fire_held;
      ack_frame_version_o <= 2'h0;
      pan_coordinator_flag_o <= ack_ctrl_r[`XR_COORD_BIT];
      if (want_ack && slotted && ack_state_r == xr_pkg::XR_ACK_IDLE)
        hold_pending_r <= pend_now;
      if (fire_now)
        ack_pending_o <= pend_now;
      else if (fire_held)
        ack_pending_o <= hold_pending_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Transaction status
  always_ff @(posedge ref_clk_i or negedge rst_n_r)
  begin
    if (!rst_n_r)
      trac_r <= xr_pkg::XR_TRAC_INVALID;
    else if (ack_state_nxt == xr_pkg::XR_ACK_HOLD)
      trac_r <= xr_pkg::XR_TRAC_AWAIT_TRIG;
    else if (fire_now || fire_held)
      trac_r <= xr_pkg::XR_TRAC_SUCCESS;
    else if (cca_busy_i && !immediate && !csma_more && !tx_start_i)
      trac_r <= xr_pkg::XR_TRAC_ACCESS_FAIL;
    else if (no_ack_i && !frame_more && !tx_start_i && !cca_busy_i)
      trac_r <= xr_pkg::XR_TRAC_NO_ACK;
  end

  assign transaction_status_o = trac_r;

endmodule // xr_ext_mode

// ---- design/xr_ext_mode_regs.svh ----
// What this block does
// - Frame retry count readable, 4 bits, resets zero
// - Backoff retry count readable in bits 3:1
// - Status counters refresh at each new cycle
// - Frame retransmissions capped by limit, then cancel
// - Backoff retries capped by limit, then cancel
// - Limit seven sends at once, no retry
// - Unslotted mode acknowledges requested frames automatically
// - Slotted mode holds ack until trigger rising edge
// - Report awaiting-trigger code while ack held
// - Host times trigger edge to slot boundary
// - Eleven bit seed from two registers
// - Seed drives backoff random generator
// - Wakeup from deepest sleep reloads generator
// - Version mode sets highest accepted frame version
// - Too new frames rejected and not acknowledged
// - Generated ack carries frame version zero
// - Ack disable suppresses new acknowledgements; a held one still goes at the trigger
// - Data request ack copies pending value bit
`ifndef XR_EXT_MODE_REGS_SVH
`define XR_EXT_MODE_REGS_SVH

// Register indexes; byte address is four times the index
`define XR_IDX_RETRY_STATUS   6'h19
`define XR_IDX_TX_CONTROL     6'h2c
`define XR_IDX_SEED_LOW       6'h2d
`define XR_IDX_ACK_CTRL_SEED  6'h2e

// Reset values
`define XR_RST_TX_CONTROL     8'h38
`define XR_RST_SEED_LOW       8'hea
`define XR_RST_ACK_CTRL_SEED  8'h42

// Field positions
`define XR_FRAME_CNT_MSB      7
`define XR_FRAME_CNT_LSB      4
`define XR_CSMA_CNT_MSB       3
`define XR_CSMA_CNT_LSB       1
`define XR_FRAME_LIM_MSB      7
`define XR_FRAME_LIM_LSB      4
`define XR_CSMA_LIM_MSB       3
`define XR_CSMA_LIM_LSB       1
`define XR_SLOTTED_BIT        0
`define XR_FVN_MSB            7
`define XR_FVN_LSB            6
`define XR_SET_PD_BIT         5
`define XR_DIS_ACK_BIT        4
`define XR_COORD_BIT          3
`define XR_SEED_HI_MSB        2

// Backoff limit that bypasses channel access
`define XR_CSMA_IMMEDIATE     3'h7

`endif

// ---- design/xr_pkg.sv ----
package xr_pkg;

  typedef enum logic [2:0] {
    XR_TRAC_SUCCESS      = 3'h0,
    XR_TRAC_AWAIT_TRIG   = 3'h1,
    XR_TRAC_ACCESS_FAIL  = 3'h3,
    XR_TRAC_NO_ACK       = 3'h5,
    XR_TRAC_INVALID      = 3'h7
  } xr_trac_t;

  typedef enum logic [0:0] {
    XR_ACK_IDLE          = 1'b0,
    XR_ACK_HOLD          = 1'b1
  } xr_ack_state_t;

endpackage

// ---- testbench/tb.sv ----
`timescale 1ns/1ps
module tb;
  logic        clk = 1'b0;
  logic        arst_n, psel, pen, pwr, pready, pslverr, go, pin;
  logic [7:0]  paddr, rd;
  logic [31:0] pwdata, prdata;
  logic [5:0]  ev;
  logic        bypass, rb, rf, cancel, aam, rx_done, ack_req, dreq;
  logic        acc, ack, pend, coord, err;
  logic [1:0]  fver, afv;
  logic [10:0] rnd;
  logic [2:0]  trac;
  int          miscompares = 0;
  int          n_compared = 0;

  always #25 clk = ~clk;

  xr_ext_mode DUT (.ref_clk_i(clk), .arst_n_i(arst_n), .psel_i(psel),
    .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
    .tx_start_i(ev[0]), .backoff_start_i(ev[1]), .frame_tx_start_i(ev[2]),
    .cca_busy_i(ev[3]), .no_ack_i(ev[4]), .wake_i(ev[5]),
    .csma_bypass_o(bypass), .retry_backoff_o(rb), .retry_frame_o(rf),
    .cancel_o(cancel), .backoff_random_o(rnd), .transaction_status_o(trac),
    .auto_acknowledge_mode_i(aam), .rx_done_i(rx_done),
    .rx_ack_req_i(ack_req), .rx_data_req_i(dreq), .rx_frame_version_i(fver),
    .sleep_trigger_pin_i(pin), .rx_accept_o(acc), .ack_send_o(ack),
    .ack_pending_o(pend), .ack_frame_version_o(afv),
    .pan_coordinator_flag_o(coord));
  xr_host_trig u_host (.ref_clk_i(clk), .go_i(go), .sleep_trigger_pin_o(pin));

  ////////////////////////////////////////////////////////////////////////////
  task automatic cmp(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e)
    begin
      miscompares++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20)
    begin
      @(posedge clk);
      n++;
    end
    // A slave that never answers counts as a mismatch
    if (pready !== 1'b1)
    begin
      miscompares++;
      $display("[FAIL] pready expected 1 seen %b", pready);
    end
    rd = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask

  task automatic pulse(input int b);
    @(posedge clk);
    ev[b] <= 1'b1;
    @(posedge clk);
    ev <= '0;
    #1;
  endtask

  task automatic rx(input logic [1:0] v, input logic dr);
    @(posedge clk);
    rx_done <= 1'b1;
    fver <= v;
    dreq <= dr;
    @(posedge clk);
    rx_done <= 1'b0;
    #1;
  endtask

  task automatic t_reset;
    apb(0, 8'h64, 8'h0); cmp("status", 8'h00, rd);
    apb(0, 8'hb0, 8'h0); cmp("txctl", 8'h38, rd);
    apb(0, 8'hb4, 8'h0); cmp("seed_lo", 8'hea, rd);
    apb(0, 8'hb8, 8'h0); cmp("ackctl", 8'h42, rd);
    apb(1, 8'h64, 8'hff);
    apb(0, 8'h64, 8'h0); cmp("status_ro", 8'h00, rd);
    apb(0, 8'h00, 8'h0); cmp("unmapped", 1, err);
  endtask

  task automatic t_retry;
    apb(1, 8'hb0, 8'h12);
    pulse(0);
    pulse(3); cmp("retry_backoff", 1, rb);
    pulse(1);
    apb(0, 8'h64, 8'h0); cmp("status_bo", 8'h02, rd);
    pulse(3); cmp("cancel_bo", 1, cancel);
    pulse(0);
    apb(0, 8'h64, 8'h0); cmp("status_clr", 8'h00, rd);
    pulse(4); cmp("retry_frame", 1, rf);
    pulse(2);
    apb(0, 8'h64, 8'h0); cmp("status_fr", 8'h10, rd);
    pulse(4); cmp("cancel_fr", 1, cancel);
  endtask

  task automatic t_bypass;
    apb(1, 8'hb0, 8'h0e);
    repeat (2) @(posedge clk);
    #1 cmp("bypass", 1, bypass);
    pulse(0);
    pulse(3); cmp("no_retry", 0, rb);
    pulse(4); cmp("cancel_now", 1, cancel);
    apb(1, 8'hb0, 8'h38);
  endtask

  task automatic t_rx;
    for (int m = 0; m < 4; m++)
    begin
      apb(1, 8'hb8, {m[1:0], 6'h02});
      for (int v = 0; v < 4; v++)
      begin
        rx(v[1:0], 1'b0);
        cmp("accept", v <= m, acc);
        cmp("ack", v <= m, ack);
        cmp("ack_ver", 0, afv);
      end
    end
    apb(1, 8'hb8, 8'h70);
    rx(2'h0, 1'b1); cmp("dis_acc", 1, acc);
    cmp("dis_ack", 0, ack);
    apb(1, 8'hb8, 8'h60);
    rx(2'h0, 1'b1); cmp("pend", 1, pend);
  endtask

  task automatic t_slotted;
    int n;
    n = 0;
    apb(1, 8'hb0, 8'h39);
    rx(2'h0, 1'b0); cmp("held", 0, ack);
    cmp("await", 3'h1, trac);
    @(posedge clk);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    while (ack !== 1'b1 && n < 10)
    begin
      @(posedge clk);
      #1 n++;
    end
    cmp("trig_ack", 1, ack);
    cmp("released", 3'h0, trac);
    apb(1, 8'hb0, 8'h38);
  endtask

  task automatic t_seed;
    apb(1, 8'hb4, 8'h5a);
    apb(1, 8'hb8, 8'h4d);
    pulse(5); cmp("reload", 11'h55a, rnd);
    cmp("coord", 1, coord);
    @(posedge clk);
    #1 cmp("shifts", 11'h2b4, rnd);
  endtask

  task automatic end_sim;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    #250000;
    miscompares++;
    end_sim;
  end

  initial
  begin
    {arst_n, psel, pen, pwr, go, rx_done, dreq} = '0;
    {paddr, pwdata, ev, fver} = '0;
    aam = 1'b1;
    ack_req = 1'b1;
    repeat (10) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    t_reset;
    t_retry;
    t_bypass;
    t_rx;
    t_slotted;
    t_seed;
    end_sim;
  end
endmodule // tb

// ---- testbench/xr_ext_mode_chk.sv ----
`timescale 1ns/1ps
module xr_ext_mode_chk
(
  // Clock, reset and bus
  input wire logic        ref_clk_i,
  input wire logic        arst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [7:0]  paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic        pready_o,
  // Transmit side
  input wire logic        tx_start_i,
  input wire logic        cca_busy_i,
  input wire logic        no_ack_i,
  input wire logic        csma_bypass_o,
  input wire logic        retry_backoff_o,
  input wire logic        retry_frame_o,
  input wire logic        cancel_o,
  input wire logic [2:0]  transaction_status_o,
  // Receive side
  input wire logic        auto_acknowledge_mode_i,
  input wire logic        rx_done_i,
  input wire logic        rx_accept_o,
  input wire logic        ack_send_o,
  input wire logic        ack_pending_o,
  input wire logic [1:0]  ack_frame_version_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_txctl_wr;
    psel_i && penable_i && pwrite_i && pready_o && paddr_i == 8'hb0;
  endsequence

  chk_bypass_write: assert property (
    s_txctl_wr |-> ##2
      csma_bypass_o == (($past(pwdata_i, 2) & 32'he) == 32'he))
    else $error("bypass level wrong after control write");
  chk_bypass_noretry: assert property (
    csma_bypass_o && cca_busy_i && !tx_start_i |=> !retry_backoff_o)
    else $error("backoff retried while bypassed");
  chk_bypass_cancel: assert property (
    csma_bypass_o && no_ack_i && !tx_start_i |=> cancel_o && !retry_frame_o)
    else $error("bypassed frame retried");
  chk_backoff_cause: assert property (
    retry_backoff_o |-> $past(cca_busy_i && !tx_start_i))
    else $error("backoff retry without busy channel");
  chk_frame_cause: assert property (
    retry_frame_o |-> $past(no_ack_i && !tx_start_i && !cca_busy_i))
    else $error("frame retry without missing ack");
  chk_accept_cause: assert property (
    rx_accept_o |-> $past(rx_done_i && auto_acknowledge_mode_i))
    else $error("accept without reception");
  chk_ack_version: assert property (
    ack_frame_version_o == 2'h0)
    else $error("ack frame version not zero");
  chk_ack_not_held: assert property (
    ack_send_o |-> transaction_status_o != 3'h1)
    else $error("ack sent while still awaiting trigger");
  chk_pending_ack: assert property (
    $rose(ack_pending_o) |-> ack_send_o)
    else $error("pending bit changed without ack");
endmodule // xr_ext_mode_chk

bind xr_ext_mode xr_ext_mode_chk u_chk (.*);

// ---- testbench/xr_host_trig.sv ----
`timescale 1ns/1ps
module xr_host_trig
(
  // Clock and command
  input  wire logic ref_clk_i,
  input  wire logic go_i,
  // Trigger pin
  output logic      sleep_trigger_pin_o
);
  logic [1:0] hold_r = 2'h0;

  // Three cycles high, so the two-cycle minimum is always met
  always_ff @(posedge ref_clk_i)
  begin
    if (go_i)
      hold_r <= 2'h3;
    else if (hold_r != 2'h0)
      hold_r <= hold_r - 2'h1;
  end

  assign sleep_trigger_pin_o = (hold_r != 2'h0);
endmodule // xr_host_trig
